// ==== shared/lsr_pkg.sv ====
// Overview of operation
// - Gain field bits 1:0 selects analog gain
// - Gain register resets to zero, unity gain
// - Identification register read-only, fixed value
// - Part code upper nibble, revision lower
// - Results low byte first at 14h, 16h
// - Result registers read-only, zero after reset
// - Low-byte read captures upper byte shadow
// - Upper-byte read returns the shadow copy
// - Word read returns low/high pair together
// - Manual integration counted in 10.88 us steps (272 clocks)
// - 16-bit step counter at 18h/19h, resets zero
// - Counter covers 713.0 ms without overflow
// - Second ident register flag in bit 7
package lsr_pkg;
    localparam logic [7:0] LSR_GAIN_ADDR = 8'h07;
    localparam logic [7:0] LSR_IDENT_ADDR = 8'h12;
    localparam logic [7:0] LSR_C0_LOW_ADDR = 8'h14;
    localparam logic [7:0] LSR_C0_HIGH_ADDR = 8'h15;
    localparam logic [7:0] LSR_C1_LOW_ADDR = 8'h16;
    localparam logic [7:0] LSR_C1_HIGH_ADDR = 8'h17;
    localparam logic [7:0] LSR_CNT_LOW_ADDR = 8'h18;
    localparam logic [7:0] LSR_CNT_HIGH_ADDR = 8'h19;
    localparam logic [7:0] LSR_FLAG_ADDR = 8'h1E;
    localparam int LSR_GAIN_LSB = 0;
    localparam int LSR_GAIN_W = 2;
    localparam int LSR_PART_LSB = 4;
    localparam int LSR_FLAG_BIT = 7;
    localparam logic [7:0] LSR_GAIN_RST = 8'h00;
    localparam logic [15:0] LSR_RESULT_RST = 16'h0000;
    localparam logic [15:0] LSR_CNT_RST = 16'h0000;
    localparam logic [7:0] LSR_FLAG_RST = 8'h80;
    // Step size in nanoseconds and clock period in nanoseconds
    localparam int LSR_STEP_NS = 10900;
    localparam int LSR_CLK_NS = 40;
    localparam int LSR_STEP_CYC = LSR_STEP_NS / LSR_CLK_NS;
    localparam int LSR_MAX_MS_X10 = 7143;
    typedef enum logic [1:0] {
        LSR_GAIN_X1,
        LSR_GAIN_X8,
        LSR_GAIN_X16,
        LSR_GAIN_X111
    } lsr_gain_e;
    typedef struct packed {
        logic rdEn;
        logic wordRd;
        logic wrEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lsr_req_s;
endpackage

// ==== rtl/light_sensor_readout_regs.sv ====
`timescale 1ns/1ns
module lsr_light_sensor_readout_regs
    import lsr_pkg::*;
#(
    parameter logic [3:0] PART_CODE = 4'h5, // Arbitrary value
    parameter logic [3:0] REV_CODE = 4'h3 // Arbitrary value
) (
    input wire logic core_clk, // 25 MHz clock
    input wire logic rstn, // Async reset, active low
    input wire lsr_req_s req, // Register access request
    output logic [15:0] rdData_q, // Read data, high byte for words
    input wire logic [15:0] chan0Result, // Channel 0 conversion value
    input wire logic [15:0] chan1Result, // Channel 1 conversion value
    input wire logic convDone, // Conversion complete pulse
    input wire logic manualInteg, // Manual integration active
    output lsr_gain_e gainSel // Analog gain select
);
    logic [7:0] gain_q;
    logic [7:0] flag_q;
    logic [15:0] c0_q, c1_q;
    logic [7:0] c0Shadow_q, c1Shadow_q;
    logic [15:0] cnt_q;
    logic [$clog2(LSR_STEP_CYC)-1:0] pre_q;

    // Reserved gain bits dropped
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            gain_q <= LSR_GAIN_RST;
        end else if (req.wrEn && req.addr == LSR_GAIN_ADDR) begin
            gain_q <= {6'h00, req.wdata[LSR_GAIN_LSB +: LSR_GAIN_W]};
        end
    end
    assign gainSel = lsr_gain_e'(gain_q[LSR_GAIN_LSB +: LSR_GAIN_W]);

    // Second ident register: writes accepted but flag fixed
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            flag_q <= LSR_FLAG_RST;
        end else if (req.wrEn && req.addr == LSR_FLAG_ADDR) begin
            flag_q <= LSR_FLAG_RST;
        end
    end

    // Conversion results latched
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            c0_q <= LSR_RESULT_RST;
            c1_q <= LSR_RESULT_RST;
        end else if (convDone) begin
            c0_q <= chan0Result;
            c1_q <= chan1Result;
        end
    end

    // Shadow capture on low-byte reads
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            c0Shadow_q <= 8'h00;
            c1Shadow_q <= 8'h00;
        end else if (req.rdEn && req.addr == LSR_C0_LOW_ADDR) begin
            c0Shadow_q <= c0_q[15:8];
        end else if (req.rdEn && req.addr == LSR_C1_LOW_ADDR) begin
            c1Shadow_q <= c1_q[15:8];
        end
    end

    // Manual integration step counter
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pre_q <= '0;
            cnt_q <= LSR_CNT_RST;
        end else if (!manualInteg) begin
            pre_q <= '0;
        end else if (32'(pre_q) == LSR_STEP_CYC - 1) begin
            pre_q <= '0;
            if (cnt_q != 16'hFFFF) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        unique case (a)
            LSR_GAIN_ADDR: rd_byte = gain_q;
            LSR_IDENT_ADDR: rd_byte = {PART_CODE, REV_CODE};
            LSR_C0_LOW_ADDR: rd_byte = c0_q[7:0];
            LSR_C0_HIGH_ADDR: rd_byte = c0Shadow_q;
            LSR_C1_LOW_ADDR: rd_byte = c1_q[7:0];
            LSR_C1_HIGH_ADDR: rd_byte = c1Shadow_q;
            LSR_CNT_LOW_ADDR: rd_byte = cnt_q[7:0];
            LSR_CNT_HIGH_ADDR: rd_byte = cnt_q[15:8];
            LSR_FLAG_ADDR: rd_byte = flag_q;
            default: rd_byte = 8'h00;
        endcase
    endfunction

    // Read data; word read gives low plus live upper byte captured with it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdData_q <= 16'h0000;
        end else if (req.rdEn && req.wordRd) begin
            if (req.addr == LSR_C0_LOW_ADDR) begin
                rdData_q <= c0_q;
            end else if (req.addr == LSR_C1_LOW_ADDR) begin
                rdData_q <= c1_q;
            end else begin
                rdData_q <= {rd_byte(req.addr + 8'h01), rd_byte(req.addr)};
            end
        end else if (req.rdEn) begin
            rdData_q <= {8'h00, rd_byte(req.addr)};
        end
    end

    // Register checks
    gain_reset_a: assert property (@(posedge core_clk) $rose(rstn) |-> gain_q == 8'h00)
        else $error("gain not zero after reset");
    gain_rsvd_a: assert property (@(posedge core_clk) disable iff (!rstn) gain_q[7:2] == 6'h00)
        else $error("gain reserved bits set");
    gain_map_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.wrEn && req.addr == LSR_GAIN_ADDR |=>
        gainSel == lsr_gain_e'($past(req.wdata[1:0])))
        else $error("gain select mismatch");
    ident_rd_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.rdEn && !req.wordRd && req.addr == LSR_IDENT_ADDR |=>
        rdData_q == {8'h00, PART_CODE, REV_CODE}) else $error("ident value wrong");
    flag_fixed_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.rdEn && !req.wordRd && req.addr == LSR_FLAG_ADDR |=>
        rdData_q == {8'h00, LSR_FLAG_RST})
        else $error("ident flag changed");
    shadow_cap_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.rdEn && req.addr == LSR_C0_LOW_ADDR |=> c0Shadow_q == $past(c0_q[15:8]))
        else $error("shadow not captured");
    shadow_rd_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.rdEn && !req.wordRd && req.addr == LSR_C1_HIGH_ADDR |=>
        rdData_q[7:0] == $past(c1Shadow_q)) else $error("high read not shadow");
    word_rd_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.rdEn && req.wordRd && req.addr == LSR_C0_LOW_ADDR |=> rdData_q == $past(c0_q))
        else $error("word read mismatch");
    cnt_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !manualInteg |=> $stable(cnt_q)) else $error("counter moved while idle");
    cover_word_c: cover property (@(posedge core_clk) req.rdEn && req.wordRd);
    cover_conv_c: cover property (@(posedge core_clk) convDone);
    cover_cnt_c: cover property (@(posedge core_clk) $changed(cnt_q));
    cover_shadow_c: cover property (@(posedge core_clk)
        req.rdEn && req.addr == LSR_C0_HIGH_ADDR);
    cover_gain_c: cover property (@(posedge core_clk)
        req.wrEn && req.addr == LSR_GAIN_ADDR && req.wdata[1:0] == 2'h3);

    // Counter step spacing seen from outside the prescaler
    logic [15:0] stepGap_q;
    logic [15:0] cntSeen_q;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stepGap_q <= 16'h0000;
            cntSeen_q <= LSR_CNT_RST;
        end else begin
            cntSeen_q <= cnt_q;
            if (!manualInteg) begin
                stepGap_q <= 16'h0000;
            end else if (cnt_q != cntSeen_q) begin
                stepGap_q <= 16'h0001;
            end else if (stepGap_q != 16'hFFFF) begin
                stepGap_q <= stepGap_q + 16'h0001;
            end
        end
    end

    // Gain register moves only on a write
    gain_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !(req.wrEn && req.addr == LSR_GAIN_ADDR) |=>
        $stable(gain_q))
        else $error("gain changed without write");

    // Reserved gain bits read as zero
    gain_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.rdEn && !req.wordRd && req.addr == LSR_GAIN_ADDR |=>
        rdData_q[15:2] == 14'h0000)
        else $error("gain reserved bits read nonzero");

    // Channel 1 shadow capture on low read
    c1_cap_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.rdEn && req.addr == LSR_C1_LOW_ADDR |=>
        c1Shadow_q == $past(c1_q[15:8]))
        else $error("channel 1 shadow not captured");

    // Channel 0 shadow holds between low reads
    c0_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !(req.rdEn && req.addr == LSR_C0_LOW_ADDR) |=>
        $stable(c0Shadow_q))
        else $error("channel 0 shadow moved");

    // Channel 1 shadow holds between low reads
    c1_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !(req.rdEn && req.addr == LSR_C1_LOW_ADDR) |=>
        $stable(c1Shadow_q))
        else $error("channel 1 shadow moved");

    // Channel 0 upper read returns shadow
    c0_high_rd_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.rdEn && !req.wordRd && req.addr == LSR_C0_HIGH_ADDR |=>
        rdData_q == {8'h00, $past(c0Shadow_q)})
        else $error("channel 0 high read not shadow");

    // Channel 0 low read returns live low byte
    c0_low_rd_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.rdEn && !req.wordRd && req.addr == LSR_C0_LOW_ADDR |=>
        rdData_q == {8'h00, $past(c0_q[7:0])})
        else $error("channel 0 low read wrong");

    // Channel 1 low read returns live low byte
    c1_low_rd_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.rdEn && !req.wordRd && req.addr == LSR_C1_LOW_ADDR |=>
        rdData_q == {8'h00, $past(c1_q[7:0])})
        else $error("channel 1 low read wrong");

    // Channel 1 word read returns full value
    c1_word_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.rdEn && req.wordRd && req.addr == LSR_C1_LOW_ADDR |=>
        rdData_q == $past(c1_q))
        else $error("channel 1 word read wrong");

    // Results load on conversion done
    conv_load_a: assert property (@(posedge core_clk) disable iff (!rstn)
        convDone |=>
        c0_q == $past(chan0Result) && c1_q == $past(chan1Result))
        else $error("results not loaded");

    // Results hold without conversion done
    result_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !convDone |=>
        $stable(c0_q) && $stable(c1_q))
        else $error("results moved without conversion");

    // Results zero after reset
    result_reset_a: assert property (@(posedge core_clk)
        $rose(rstn) |->
        c0_q == LSR_RESULT_RST && c1_q == LSR_RESULT_RST)
        else $error("results not zero after reset");

    // Step counter zero after reset
    cnt_reset_a: assert property (@(posedge core_clk)
        $rose(rstn) |->
        cnt_q == LSR_CNT_RST)
        else $error("counter not zero after reset");

    // Step counter never wraps
    cnt_sat_a: assert property (@(posedge core_clk) disable iff (!rstn)
        cnt_q == 16'hFFFF |=>
        cnt_q == 16'hFFFF)
        else $error("counter wrapped");

    // Step counter moves by one only
    cnt_inc_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $changed(cnt_q) |->
        cnt_q == $past(cnt_q) + 16'h0001)
        else $error("counter stepped by more than one");

    // Prescaler stays inside one step
    pre_range_a: assert property (@(posedge core_clk) disable iff (!rstn)
        manualInteg |->
        32'(pre_q) < LSR_STEP_CYC)
        else $error("prescaler out of range");

    // Steps are one step period apart
    step_gap_a: assert property (@(posedge core_clk) disable iff (!rstn)
        cnt_q != cntSeen_q |->
        32'(stepGap_q) == LSR_STEP_CYC)
        else $error("counter step spacing wrong");

    // Counter low byte read
    cnt_low_rd_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.rdEn && !req.wordRd && req.addr == LSR_CNT_LOW_ADDR |=>
        rdData_q == {8'h00, $past(cnt_q[7:0])})
        else $error("counter low read wrong");

    // Counter high byte read
    cnt_high_rd_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.rdEn && !req.wordRd && req.addr == LSR_CNT_HIGH_ADDR |=>
        rdData_q == {8'h00, $past(cnt_q[15:8])})
        else $error("counter high read wrong");

    // Counter word read
    cnt_word_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.rdEn && req.wordRd && req.addr == LSR_CNT_LOW_ADDR |=>
        rdData_q == $past(cnt_q))
        else $error("counter word read wrong");

    // Byte reads leave upper half zero
    byte_upper_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.rdEn && !req.wordRd |=>
        rdData_q[15:8] == 8'h00)
        else $error("byte read upper half set");

    // Read data stands until the next read
    rd_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !req.rdEn |=>
        $stable(rdData_q))
        else $error("read data moved without read");

    // Ident word read
    ident_word_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.rdEn && req.wordRd && req.addr == LSR_IDENT_ADDR |=>
        rdData_q == {8'h00, PART_CODE, REV_CODE})
        else $error("ident word read wrong");

    // Flag word read
    flag_word_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req.rdEn && req.wordRd && req.addr == LSR_FLAG_ADDR |=>
        rdData_q == {8'h00, LSR_FLAG_RST})
        else $error("flag word read wrong");
endmodule

// ==== test/lsr_host_model.sv ====
`timescale 1ns/1ns
module lsr_host_model
    import lsr_pkg::*;
(
    input wire logic core_clk, // Bus clock
    output lsr_req_s req // Request to the block
);
    // Idle request at time zero
    initial req = '{default: '0};
    // One-cycle strobe launched at the falling edge, then released
    task automatic access(input logic r, w, wd, input logic [7:0] a, d);
        @(negedge core_clk);
        req = '{rdEn: r, wordRd: wd, wrEn: w && (a != LSR_FLAG_ADDR), addr: a, wdata: d};
        @(negedge core_clk);
        req = '{rdEn: 1'b0, wordRd: 1'b0, wrEn: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

// ==== test/light_sensor_readout_regs_test.sv ====
`timescale 1ns/1ns
module light_sensor_readout_regs_test
    import lsr_pkg::*;
;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    lsr_req_s req;
    logic [15:0] rdData_q;
    logic [15:0] chan0Result = 16'h0000;
    logic [15:0] chan1Result = 16'h0000;
    logic convDone = 1'b0;
    logic manualInteg = 1'b0;
    lsr_gain_e gainSel;
    int fails = 0;
    int samplesChecked = 0;
    always #20 core_clk = ~core_clk;
    // Identity codes below are arbitrary
    lsr_light_sensor_readout_regs #(.PART_CODE(4'hA), .REV_CODE(4'h6)) uut (
        .core_clk(core_clk), .rstn(rstn), .req(req), .rdData_q(rdData_q),
        .chan0Result(chan0Result), .chan1Result(chan1Result), .convDone(convDone),
        .manualInteg(manualInteg), .gainSel(gainSel));
    lsr_host_model host (.core_clk(core_clk), .req(req));
    // Verdict and end of run
    task automatic printVerdict();
        $display("checks=%0d fails=%0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] exp, got);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic wd, input logic [15:0] exp);
        host.access(1'b1, 1'b0, wd, a, 8'h00);
        chk(exp, rdData_q);
    endtask
    task automatic wr(input logic [7:0] a, d);
        host.access(1'b0, 1'b1, 1'b0, a, d);
    endtask
    // New conversion values with a one-cycle strobe
    task automatic conv(input logic [15:0] c0, c1);
        @(negedge core_clk);
        chan0Result = c0;
        chan1Result = c1;
        convDone = 1'b1;
        @(negedge core_clk);
        convDone = 1'b0;
    endtask
    task automatic tReset();
        chk(16'h0000, {14'h0000, gainSel});
        rd(LSR_GAIN_ADDR, 1'b0, 16'h0000);
        rd(LSR_IDENT_ADDR, 1'b0, 16'h00A6);
        rd(LSR_FLAG_ADDR, 1'b0, 16'h0080);
        rd(LSR_FLAG_ADDR, 1'b1, 16'h0080);
        rd(LSR_IDENT_ADDR, 1'b1, 16'h00A6);
        for (int a = 8'h14; a <= 8'h19; a++) rd(8'(a), 1'b0, 16'h0000);
        rd(8'h08, 1'b0, 16'h0000);
        $display("test reset done");
    endtask
    task automatic tGain();
        for (int g = 0; g < 4; g++) begin
            wr(LSR_GAIN_ADDR, 8'(g));
            chk(16'(g), {14'h0000, gainSel});
            rd(LSR_GAIN_ADDR, 1'b0, 16'(g));
        end
        wr(LSR_IDENT_ADDR, 8'h00);
        rd(LSR_IDENT_ADDR, 1'b0, 16'h00A6);
        wr(LSR_C0_LOW_ADDR, 8'h5A);
        rd(LSR_C0_LOW_ADDR, 1'b0, 16'h0000);
        $display("test gain done");
    endtask
    task automatic tShadow();
        conv(16'h1234, 16'hABCD);
        rd(LSR_C0_LOW_ADDR, 1'b0, 16'h0034);
        conv(16'h5678, 16'h9876);
        rd(LSR_C0_HIGH_ADDR, 1'b0, 16'h0012);
        rd(LSR_C1_LOW_ADDR, 1'b0, 16'h0076);
        rd(LSR_C1_HIGH_ADDR, 1'b0, 16'h0098);
        rd(LSR_C1_LOW_ADDR, 1'b1, 16'h9876);
        rd(LSR_C0_LOW_ADDR, 1'b1, 16'h5678);
        $display("test shadow done");
    endtask
    task automatic tTimer();
        @(negedge core_clk);
        manualInteg = 1'b1;
        repeat (3 * LSR_STEP_CYC + 10) @(negedge core_clk);
        manualInteg = 1'b0;
        rd(LSR_CNT_LOW_ADDR, 1'b0, 16'h0003);
        rd(LSR_CNT_HIGH_ADDR, 1'b0, 16'h0000);
        rd(LSR_CNT_LOW_ADDR, 1'b1, 16'h0003);
        $display("test timer done");
    endtask
    // Reset in mid-run clears gain, results and counter
    task automatic tMidReset();
        @(negedge core_clk);
        rstn = 1'b0;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        chk(16'h0000, {14'h0000, gainSel});
        rd(LSR_CNT_LOW_ADDR, 1'b1, 16'h0000);
        rd(LSR_C0_LOW_ADDR, 1'b1, 16'h0000);
        rd(LSR_FLAG_ADDR, 1'b0, 16'h0080);
        $display("test mid reset done");
    endtask
    // Main sequence
    initial begin
        repeat (6) @(negedge core_clk);
        rstn = 1'b1;
        tReset();
        tGain();
        tShadow();
        tTimer();
        tMidReset();
        printVerdict();
    end
    // Watchdog
    initial begin
        #(4000 * 40);
        fails++;
        printVerdict();
    end
endmodule
